// ### hw/cms_ctrl.v
// Purpose: per-channel mode control, activity indicators, send-immediate/wake
// Assumes: all inputs synchronous to pclk except the send-immediate pins
// Notes:   registers on APB, zero wait states after the setup cycle
`timescale 1ns/1ps
`default_nettype none
`include "cms_regs.vh"

// ----------------------------------------
// Retriggerable one-shot
// ----------------------------------------
module cms_oneshot #(
	parameter [`CMS_CNT_W-1:0] CYC = 24'h000010
) (
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	// Control
	input  wire en,
	input  wire trig,
	// Result
	output reg  active_q
);
	reg [`CMS_CNT_W-1:0] cnt_q;

	// Activity reloads the timer instead of ending the pulse early
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= {`CMS_CNT_W{1'b0}};
			active_q <= 1'b0;
		end else if (!en) begin
			cnt_q    <= {`CMS_CNT_W{1'b0}};
			active_q <= 1'b0;
		end else if (trig) begin
			cnt_q    <= CYC - 1'b1;            // [RQ3] [RQ4]
			active_q <= 1'b1;
		end else if (cnt_q != {`CMS_CNT_W{1'b0}}) begin
			cnt_q    <= cnt_q - 1'b1;
		end else begin
			active_q <= 1'b0;
		end
	end
endmodule

// ----------------------------------------
// Send-immediate / wake detector
// ----------------------------------------
module cms_send_immediate_wake_n #(
	parameter [`CMS_CNT_W-1:0] WAKE_CYC = 24'h000010
) (
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	// Pin and mode gate
	input  wire send_immediate_wake_n,
	input  wire en,
	// Events
	output reg  flush_q,
	output reg  wake_q
);
	reg                  s1_q;
	reg                  s2_q;
	reg                  s3_q;
	reg [`CMS_CNT_W-1:0] low_q;

	// Two-stage synchroniser, third stage only for edge finding
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= send_immediate_wake_n;      // [RQ10]
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Falling edge flushes; a long enough low asks for wakeup once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q   <= {`CMS_CNT_W{1'b0}};
			flush_q <= 1'b0;
			wake_q  <= 1'b0;
		end else begin
			flush_q <= en & s3_q & ~s2_q;       // [RQ5] [RQ6] [RQ7]
			wake_q  <= 1'b0;
			if (s2_q) begin
				low_q <= {`CMS_CNT_W{1'b0}};
			end else if (low_q != WAKE_CYC) begin
				low_q <= low_q + 1'b1;
				// Saturating count gives one request per low pulse
				if (low_q == WAKE_CYC - 1'b1) begin
					wake_q <= en;               // [RQ9]
				end
			end
		end
	end
endmodule

// ----------------------------------------
// Top: channel mode select controller
// ----------------------------------------
module cms_ctrl #(
	parameter [`CMS_CNT_W-1:0] LED_CYC  = `CMS_LED_MS * `CMS_CLK_KHZ,
	parameter [`CMS_CNT_W-1:0] WAKE_CYC = `CMS_WAKE_MS * `CMS_CLK_KHZ
) (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Configuration memory
	output reg         cfg_rd_q,
	input  wire        cfg_valid,
	input  wire [3:0]  cfg_mode_a,
	input  wire [3:0]  cfg_mode_b,
	// Channel activity
	input  wire        tx_act_a,
	input  wire        rx_act_a,
	input  wire        tx_act_b,
	input  wire        rx_act_b,
	// Send-immediate / wake pins
	input  wire        send_immediate_wake_n_a,
	input  wire        send_immediate_wake_n_b,
	// Indicator pins, open drain
	output reg         led_level_q,
	output reg  [3:0]  led_oe_q,
	// Channel control
	output reg  [3:0]  mode_a_q,
	output reg  [3:0]  mode_b_q,
	output reg         b_freeze_q,
	output reg         b_idle_default_q,
	output reg         flush_a_q,
	output reg         flush_b_q,
	output reg         wake_q
);
	// States
	localparam [2:0] ST_RESET = 3'b001;
	localparam [2:0] ST_LOAD  = 3'b010;
	localparam [2:0] ST_RUN   = 3'b100;

	reg  [2:0]  state_q;
	reg  [3:0]  stored_a_q;
	reg  [3:0]  stored_b_q;
	reg         b_used_q;
	reg  [4:0]  event_q;
	reg  [4:0]  ev_set;
	reg  [3:0]  sel_mode;
	reg         sel_ok;
	wire        acc_wr;
	wire        acc;
	wire [3:0]  led_act;
	wire [3:0]  led_trig;
	wire        fl_a;
	wire        fl_b;
	wire        wk_a;
	wire        wk_b;
	wire [7:0]  cmd_val;
	wire        cmd_chb;
	wire [3:0]  cur_mode;

	// ----------------------------------------
	// Mode helpers
	// ----------------------------------------
	// Writes take effect only on the edge where pready is seen; read data is latched in the setup cycle
	assign acc     = psel & penable & pready;
	assign acc_wr  = acc & pwrite;
	assign cmd_val = pwdata[`CMS_CMD_VAL];
	assign cmd_chb = pwdata[`CMS_CMD_CHB];
	assign cur_mode = cmd_chb ? mode_b_q : mode_a_q;

	// FIFO and bit-bang modes only; B is dead while frozen
	function fifo_like;
		input [3:0] m;
		begin
			fifo_like = (m == `CMS_MODE_AFIFO) | (m == `CMS_MODE_SFIFO) |
				(m == `CMS_MODE_CPU) | (m == `CMS_MODE_ABB) | (m == `CMS_MODE_SBB);
		end
	endfunction

	// Map stored code; only configuration-memory modes pass, else serial
	function [3:0] stored_map;
		input [3:0] c;
		begin
			case (c)
				`CMS_MODE_AFIFO, `CMS_MODE_SFIFO,
				`CMS_MODE_FSER,  `CMS_MODE_CPU:  stored_map = c;   // [RQ20]
				default:                         stored_map = `CMS_MODE_UART;
			endcase
		end
	endfunction

	// Decode a host mode command and check that it is legal now
	always @* begin
		sel_mode = cur_mode;
		sel_ok   = 1'b1;
		case (cmd_val)
			`CMS_SEL_STORED: sel_mode = cmd_chb ? stored_b_q : stored_a_q;
			`CMS_SEL_ABB:    sel_mode = `CMS_MODE_ABB;             // [RQ13] [RQ14]
			`CMS_SEL_SBB:    sel_mode = `CMS_MODE_SBB;             // [RQ14]
			`CMS_SEL_ENGINE: sel_mode = `CMS_MODE_ENGINE;          // [RQ13]
			`CMS_SEL_HBE:    sel_mode = `CMS_MODE_HBE;             // [RQ20]
			`CMS_SEL_SFIFO: begin
				// Both channels must sit in async FIFO first
				sel_mode = `CMS_MODE_SFIFO;                         // [RQ15]
				sel_ok   = !cmd_chb && (mode_a_q == `CMS_MODE_AFIFO) &&
					(mode_b_q == `CMS_MODE_AFIFO);                  // [RQ16]
			end
			default:         sel_ok = 1'b0;
		endcase
		// Channel B refuses commands while lent to A
		if (cmd_chb && b_freeze_q) begin
			sel_ok = 1'b0;                                          // [RQ17]
		end
	end

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	// Serial on reset, stored modes once read, then host commands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_RESET;
			cfg_rd_q   <= 1'b0;
			mode_a_q   <= `CMS_MODE_UART;                      // [RQ11]
			mode_b_q   <= `CMS_MODE_UART;
			stored_a_q <= `CMS_MODE_UART;
			stored_b_q <= `CMS_MODE_UART;
		end else begin
			case (state_q)
				ST_RESET: begin
					cfg_rd_q <= 1'b1;
					state_q  <= ST_LOAD;
				end
				ST_LOAD: begin
					if (cfg_valid) begin
						cfg_rd_q   <= 1'b0;
						stored_a_q <= stored_map(cfg_mode_a);
						stored_b_q <= stored_map(cfg_mode_b);
						mode_a_q   <= stored_map(cfg_mode_a);      // [RQ12]
						mode_b_q   <= stored_map(cfg_mode_b);
						state_q    <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (acc_wr && paddr == `CMS_OFF_CMD && sel_ok) begin
						if (cmd_chb) begin
							mode_b_q <= sel_mode;
						end else begin
							mode_a_q <= sel_mode;
						end
					end
				end
				default: state_q <= ST_RESET;
			endcase
		end
	end

	// ----------------------------------------
	// Channel B lending and freeze
	// ----------------------------------------
	// B pins hold at the switch; a never-used B shows idle defaults
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_used_q         <= 1'b0;
			b_freeze_q       <= 1'b0;
			b_idle_default_q <= 1'b0;
		end else begin
			b_used_q         <= b_used_q | ((tx_act_b | rx_act_b) & ~b_freeze_q);
			b_freeze_q       <= (mode_a_q == `CMS_MODE_SFIFO);               // [RQ17] [RQ18]
			b_idle_default_q <= (mode_a_q == `CMS_MODE_SFIFO) & ~b_used_q;   // [RQ18]
		end
	end

	// ----------------------------------------
	// Activity indicators
	// ----------------------------------------
	assign led_trig = {rx_act_b, tx_act_b, rx_act_a, tx_act_a};

	// One timer per indicator: A tx, A rx, B tx, B rx
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_led
			cms_oneshot #(
				.CYC      (LED_CYC)
			) u_shot (
				.pclk     (pclk),
				.presetn  (presetn),
				.en       (((gi < 2) ? mode_a_q : mode_b_q) == `CMS_MODE_UART), // [RQ1]
				.trig     (led_trig[gi]),
				.active_q (led_act[gi])
			);
		end
	endgenerate

	// Open drain: level is always low, enable only while active
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_level_q <= 1'b0;
			led_oe_q    <= 4'h0;
		end else begin
			led_level_q <= 1'b0;
			led_oe_q    <= led_act;                  // [RQ2]
		end
	end

	// ----------------------------------------
	// Send-immediate / wake
	// ----------------------------------------
	cms_send_immediate_wake_n #(
		.WAKE_CYC              (WAKE_CYC)
	) u_send_immediate_wake_n_a (
		.pclk                  (pclk),
		.presetn               (presetn),
		.send_immediate_wake_n (send_immediate_wake_n_a),
		.en                    (fifo_like(mode_a_q)),    // [RQ5]
		.flush_q               (fl_a),
		.wake_q                (wk_a)
	);

	cms_send_immediate_wake_n #(
		.WAKE_CYC              (WAKE_CYC)
	) u_send_immediate_wake_n_b (
		.pclk                  (pclk),
		.presetn               (presetn),
		.send_immediate_wake_n (send_immediate_wake_n_b),
		.en                    (fifo_like(mode_b_q) & ~b_freeze_q), // [RQ5] [RQ17]
		.flush_q               (fl_b),
		.wake_q                (wk_b)
	);

	// Re-time to keep outputs straight from flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_a_q <= 1'b0;
			flush_b_q <= 1'b0;
			wake_q    <= 1'b0;
		end else begin
			flush_a_q <= fl_a;                       // [RQ6]
			flush_b_q <= fl_b;
			wake_q    <= wk_a | wk_b;                // [RQ9]
		end
	end

	// ----------------------------------------
	// Sticky events
	// ----------------------------------------
	always @* begin
		ev_set = 5'h00;
		ev_set[`CMS_EV_FLUSH_A] = fl_a;
		ev_set[`CMS_EV_FLUSH_B] = fl_b;
		ev_set[`CMS_EV_WAKE_A]  = wk_a;
		ev_set[`CMS_EV_WAKE_B]  = wk_b;
		ev_set[`CMS_EV_CMD_ERR] = acc_wr && paddr == `CMS_OFF_CMD &&
			(!sel_ok || state_q != ST_RUN);
	end

	// Set beats a same-cycle write-one clear so no event is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_q <= 5'h00;
		end else if (acc_wr && paddr == `CMS_OFF_EVENT) begin
			event_q <= (event_q & ~pwdata[4:0]) | ev_set;
		end else begin
			event_q <= event_q | ev_set;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Ready one cycle after setup; unmapped addresses answer with an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
					`CMS_OFF_CMD:    prdata <= {24'h000000, mode_b_q, mode_a_q};
					`CMS_OFF_STATUS: prdata <= {22'h000000, b_used_q, b_idle_default_q,
						b_freeze_q, state_q, stored_b_q[1:0], stored_a_q[1:0]};
					`CMS_OFF_EVENT:  prdata <= {27'h0000000, event_q};
					`CMS_OFF_ACT:    prdata <= {28'h0000000, led_act};
					default:         pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/cms_regs.vh
// Purpose: constants for the channel mode select controller
// Assumes: 100 MHz pclk, APB register access
// Notes:   definitions only
//
// Contract
// RQ1 - In UART mode each channel drives a transmit and a receive activity indicator.
// RQ2 - Indicators float when idle and pull low while their direction is active.
// RQ3 - Each indicator runs through a retriggerable one-shot so brief traffic shows.
// RQ4 - One-shot length is a long parameter; new activity restarts the pulse.
// RQ5 - Send-immediate/wake input is honoured only in FIFO and bit-bang modes.
// RQ6 - Send-immediate flushes pending transmit data at once as a short packet.
// RQ7 - Send-immediate is recognised on the falling edge, not the level.
// RQ8 - External logic pulses send-immediate only after it stopped writing data.
// RQ9 - A 20 ms low pulse on the input is a remote-wakeup request.
// RQ10 - The input is synchronised before edge detection and length measurement.
// RQ11 - After reset both channels are asynchronous serial before configuration loads.
// RQ12 - After reset the stored mode of each channel is read and applied.
// RQ13 - Host mode command switches a channel to bit-bang or serial-engine modes.
// RQ14 - Command value 1 selects async bit-bang, value 4 selects sync bit-bang.
// RQ15 - In parallel FIFO mode value 0x40 selects synchronous FIFO.
// RQ16 - Synchronous FIFO is allowed only when both channels are async FIFO; the loader applies a stored sync FIFO code without this check.
// RQ17 - In synchronous FIFO channel A takes channel B's buffer; B is unavailable.
// RQ18 - On the switch channel B pins freeze; unused B shows idle defaults.
// RQ19 - Host software sets channel B pins to inputs before synchronous FIFO.
// RQ20 - Stored config sets serial/FIFO modes; host commands set the others.
`ifndef CMS_REGS_VH
`define CMS_REGS_VH

// Timing
`define CMS_CLK_KHZ        100000
`define CMS_LED_MS         50
`define CMS_WAKE_MS        20
`define CMS_CNT_W          24

// Register byte offsets
`define CMS_OFF_CMD        12'h000
`define CMS_OFF_STATUS     12'h004
`define CMS_OFF_EVENT      12'h008
`define CMS_OFF_ACT        12'h00C

// Command register fields
`define CMS_CMD_VAL        7:0
`define CMS_CMD_CHB        8

// Event register bits (write one to clear)
`define CMS_EV_FLUSH_A     0
`define CMS_EV_FLUSH_B     1
`define CMS_EV_WAKE_A      2
`define CMS_EV_WAKE_B      3
`define CMS_EV_CMD_ERR     4

// Internal mode codes
`define CMS_MODE_UART      4'h0
`define CMS_MODE_AFIFO     4'h1
`define CMS_MODE_SFIFO     4'h2
`define CMS_MODE_FSER      4'h3
`define CMS_MODE_CPU       4'h4
`define CMS_MODE_ABB       4'h5
`define CMS_MODE_SBB       4'h6
`define CMS_MODE_ENGINE    4'h7
`define CMS_MODE_HBE       4'h8

// Host mode command values
`define CMS_SEL_STORED     8'h00
`define CMS_SEL_ABB        8'h01
`define CMS_SEL_ENGINE     8'h02
`define CMS_SEL_SBB        8'h04
`define CMS_SEL_HBE        8'h08
`define CMS_SEL_SFIFO      8'h40

`endif

// ### tb/cms_cfg_mem.sv
// Purpose: configuration memory answering the mode loader
// Assumes: one read request after each reset
// Notes:   mode lines show the inverse pattern outside the answer
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Memory model
// ----------------------------
module cms_cfg_mem #(
	parameter int DLY = 3
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Request and stored modes
	input  wire logic       cfg_rd_q,
	input  wire logic [3:0] sa,
	input  wire logic [3:0] sb,
	// Answer
	output logic            cfg_valid,
	output logic [3:0]      cfg_mode_a,
	output logic [3:0]      cfg_mode_b
);
	int n;
	// Answer a pending read after DLY cycles, one cycle wide
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n <= 0;
			cfg_valid <= 1'b0;
		end else begin
			cfg_valid <= cfg_rd_q && !cfg_valid && n == DLY;
			n <= (cfg_rd_q && n < DLY) ? n + 1 : 0;
		end
	end
	// Nothing valid outside the answer, so never show the stored value
	assign cfg_mode_a = cfg_valid ? sa : ~sa;
	assign cfg_mode_b = cfg_valid ? sb : ~sb;
endmodule
`default_nettype wire

// ### tb/cms_ctrl_properties.sv
// Purpose: port checks on the mode controller
// Assumes: one-shot length of at least 8 cycles
// Notes:   bound to the controller at the foot
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Checker
// ----------------------------
module cms_ctrl_chk (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Observed ports
	input wire logic       cfg_rd_q,
	input wire logic       cfg_valid,
	input wire logic       tx_act_a,
	input wire logic       send_immediate_wake_n_a,
	input wire logic       led_level_q,
	input wire logic [3:0] led_oe_q,
	input wire logic [3:0] mode_a_q,
	input wire logic [3:0] mode_b_q,
	input wire logic       b_freeze_q,
	input wire logic       flush_a_q,
	input wire logic       flush_b_q,
	input wire logic       wake_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Indicators only ever pull low
	a_led_open_drain: assert property (led_level_q == 1'b0)
		else $error("indicator level not low");
	a_led_turn_on: assert property (mode_a_q == 4'h0 && tx_act_a ##1 mode_a_q == 4'h0
		|=> led_oe_q[0]) else $error("indicator missed activity");
	a_led_hold_min: assert property ($rose(led_oe_q[0]) |-> led_oe_q[0] [*8])
		else $error("indicator pulse too short");
	// Flush only in FIFO or bit-bang modes, one cycle wide
	a_flush_gate: assert property (flush_a_q |-> mode_a_q inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6})
		else $error("flush in wrong mode");
	a_flush_single: assert property (flush_a_q |=> !flush_a_q)
		else $error("flush held on level");
	// Two sync stages, edge stage and output flop put the pin edge four cycles back
	a_flush_edge: assert property (flush_a_q |->
		!$past(send_immediate_wake_n_a, 4) && $past(send_immediate_wake_n_a, 5))
		else $error("flush without falling edge");
	a_flush_b_gate: assert property (flush_b_q |-> !b_freeze_q && mode_b_q inside {4'h1, 4'h4, 4'h5, 4'h6})
		else $error("flush b in wrong mode");
	a_wake_single: assert property (wake_q |=> !wake_q)
		else $error("wake held");
	// Lending channel b needs both channels in async FIFO first
	a_sfifo_entry: assert property ($rose(b_freeze_q) |-> mode_a_q == 4'h2 && mode_b_q == 4'h1)
		else $error("sync FIFO without both async FIFO");
	a_freeze_hold: assert property (b_freeze_q && $past(b_freeze_q) |-> $stable(mode_b_q))
		else $error("frozen channel changed");
	a_load_uart: assert property (cfg_rd_q |-> mode_a_q == 4'h0 && mode_b_q == 4'h0)
		else $error("mode not serial before load");
	a_load_done: assert property (cfg_rd_q && cfg_valid |=> !cfg_rd_q)
		else $error("load request not dropped");
endmodule
bind cms_ctrl cms_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .cfg_rd_q(cfg_rd_q),
	.cfg_valid(cfg_valid), .tx_act_a(tx_act_a), .led_level_q(led_level_q),
	.send_immediate_wake_n_a(send_immediate_wake_n_a),
	.led_oe_q(led_oe_q), .mode_a_q(mode_a_q), .mode_b_q(mode_b_q), .b_freeze_q(b_freeze_q),
	.flush_a_q(flush_a_q), .flush_b_q(flush_b_q), .wake_q(wake_q));
`default_nettype wire

// ### tb/cms_ctrl_tb.sv
// Purpose: self-checking bench for the mode controller
// Assumes: one-shot 20 cycles, wake 30 cycles
// Notes:   mode and event model kept in ints
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Bench
// ----------------------------
module cms_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        cfg_rd_q, cfg_valid, led_level_q, b_freeze_q, b_idle_default_q;
	logic        flush_a_q, flush_b_q, wake_q;
	logic [1:0]  send_immediate_wake_n_n;
	logic [3:0]  act, sa, sb, cma, cmb, led_oe_q, mode_a_q, mode_b_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          err_total, comparisons, nwk, ewk, ma, mb, ev, i;
	int          nf[2], ef[2];
	int          sel[5] = '{1, 4, 2, 8, 0};
	cms_ctrl #(.LED_CYC(24'h000014), .WAKE_CYC(24'h00001E)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cfg_rd_q(cfg_rd_q), .cfg_valid(cfg_valid), .cfg_mode_a(cma), .cfg_mode_b(cmb),
		.tx_act_a(act[0]), .rx_act_a(act[1]), .tx_act_b(act[2]), .rx_act_b(act[3]),
		.send_immediate_wake_n_a(send_immediate_wake_n_n[0]), .send_immediate_wake_n_b(send_immediate_wake_n_n[1]),
		.led_level_q(led_level_q), .led_oe_q(led_oe_q), .mode_a_q(mode_a_q),
		.mode_b_q(mode_b_q), .b_freeze_q(b_freeze_q), .b_idle_default_q(b_idle_default_q),
		.flush_a_q(flush_a_q), .flush_b_q(flush_b_q), .wake_q(wake_q));
	cms_cfg_mem u_mem (.pclk(pclk), .presetn(presetn), .cfg_rd_q(cfg_rd_q), .sa(sa),
		.sb(sb), .cfg_valid(cfg_valid), .cfg_mode_a(cma), .cfg_mode_b(cmb));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Count event pulses as the design raises them
	always @(posedge pclk) begin
		nf[0] += (flush_a_q === 1'b1);
		nf[1] += (flush_b_q === 1'b1);
		nwk += (wake_q === 1'b1);
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			err_total++;
		end
	endtask
	// One APB transfer, then one idle cycle so the next never collides
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Model of the host command, then compare modes and read back
	task automatic mode_cmd(input int ch, input int v);
		int m;
		m = v == 1 ? 5 : v == 4 ? 6 : v == 2 ? 7 : v == 8 ? 8 : v == 0 ? (ch ? sb : sa) : 15;
		if (v == 64 && ch == 0 && ma == 1 && mb == 1) m = 2;
		if (ch == 1 && ma == 2) m = 15;
		apb(1'b1, 12'h000, 32'(ch * 256 + v));
		tick(2);
		if (m == 15) ev = 1;
		else if (ch == 1) mb = m;
		else ma = m;
		chk("mode_a", ma, mode_a_q);
		chk("mode_b", mb, mode_b_q);
		chk("freeze", ma == 2, b_freeze_q);
		apb(1'b0, 12'h000, 32'h00000000);
		chk("cmd_read", mb * 16 + ma, {24'h000000, rd[7:0]});
	endtask
	// Low pulse on a send-immediate pin, model decides the events
	task automatic pulse(input int ch, input int len);
		logic ok;
		ok = (ch ? mb : ma) inside {1, 2, 4, 5, 6};
		send_immediate_wake_n_n[ch] <= 1'b0;
		tick(len);
		send_immediate_wake_n_n[ch] <= 1'b1;
		tick(12);
		if (ok) ef[ch]++;
		if (ok && len >= 30) ewk++;
		chk("flush", ef[ch], nf[ch]);
		chk("wake", ewk, nwk);
	endtask
	task automatic start_up();
		presetn <= 1'b0;
		tick(3);
		presetn <= 1'b1;
		tick(2);
		chk("load_req", 32'h00000001, cfg_rd_q);
		chk("reset_mode", 32'h00000000, {mode_b_q, mode_a_q});
		while (cfg_rd_q !== 1'b0) @(posedge pclk);
		tick(2);
		ma = sa;
		mb = sb;
		chk("stored_mode", mb * 16 + ma, {mode_b_q, mode_a_q});
		apb(1'b0, 12'h004, 32'h00000000);
		chk("status", 64 + (sb & 3) * 4 + (sa & 3), rd);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Watchdog far beyond the expected run length
	initial begin
		tick(5000);
		err_total++;
		$display("watchdog expired");
		complete_run();
	end
	initial begin
		void'($urandom(98));
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{act, send_immediate_wake_n_n, presetn} = 7'h06;
		sa = 4'h1;
		sb = 4'h1;
		start_up();
		for (i = 0; i < 5; i++) mode_cmd(0, sel[i]);
		// Host keeps channel B idle as inputs before lending it to A
		mode_cmd(0, 64);
		chk("idle_default", 32'h00000001, b_idle_default_q);
		mode_cmd(1, 1);
		mode_cmd(0, 0);
		$display("test commands done");
		pulse(0, 3 + $urandom % 6);
		pulse(0, 40);
		mode_cmd(1, 1);
		pulse(1, 3 + $urandom % 6);
		mode_cmd(0, 64);
		mode_cmd(1, 64);
		mode_cmd(0, 16);
		// Expected sticky events from the model counters
		i = (ewk > 0) * 4 + (ef[1] > 0) * 2 + (ef[0] > 0);
		apb(1'b0, 12'h008, 32'h00000000);
		chk("cmd_error", ev * 16 + i, rd);
		apb(1'b1, 12'h008, 32'h00000010);
		apb(1'b0, 12'h008, 32'h00000000);
		chk("error_clear", i, rd);
		apb(1'b0, 12'h010, 32'h00000000);
		chk("unmapped", 32'h00000001, er);
		$display("test send_immediate_wake_n and refusals done");
		sa = 4'h0;
		sb = 4'h3;
		start_up();
		act <= 4'hF;
		tick(1);
		act <= 4'h0;
		tick(3);
		chk("led_on", 32'h00000003, led_oe_q);
		chk("led_level", 32'h00000000, led_level_q);
		apb(1'b0, 12'h00C, 32'h00000000);
		chk("act_read", 32'h00000003, rd);
		tick(10);
		act <= 4'h1;
		tick(1);
		act <= 4'h0;
		tick(17);
		chk("led_retrig", 32'h00000001, led_oe_q);
		tick(10);
		chk("led_off", 32'h00000000, led_oe_q);
		apb(1'b0, 12'h004, 32'h00000000);
		chk("b_used", 32'h0000024C, rd);
		pulse(0, 5);
		pulse(1, 40);
		$display("test indicators done");
		complete_run();
	end
endmodule
`default_nettype wire
